// file: hdl/ttc_fall.sv
// falling edge detector for a group of synchronous pins.
// assumes the pins are already synchronous to ref_clk.
`timescale 1ns/1ps
module ttc_fall #(
	parameter int W = 4
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] level,
	output logic [W-1:0] fall
);
	import ttc_pkg::*;

	logic [W-1:0] prev_r;

	generate
		if (W < 1) begin : g_chk
			$error("ttc_fall needs W of at least one");
		end
	endgenerate

	// prev resets high so a pin already low at reset shows as a falling edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_r <= '1;
		end else begin
			prev_r <= level;
		end
	end

	assign fall = prev_r & ~level;

endmodule : ttc_fall

// file: hdl/ttc_pkg.sv
// constants, modes and carriers shared by the three-timer counter unit.
// assumes one core clock and a special function register port from the core.

package ttc_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [7:0] TTC_ADR_T0_LO = 8'h8a;
	localparam logic [7:0] TTC_ADR_T1_LO = 8'h8b;
	localparam logic [7:0] TTC_ADR_T0_HI = 8'h8c;
	localparam logic [7:0] TTC_ADR_T1_HI = 8'h8d;
	localparam logic [7:0] TTC_ADR_T2_CTL = 8'hc8;
	localparam logic [7:0] TTC_ADR_T2_SNAP_LO = 8'hca;
	localparam logic [7:0] TTC_ADR_T2_SNAP_HI = 8'hcb;
	localparam logic [7:0] TTC_ADR_T2_LO = 8'hcc;
	localparam logic [7:0] TTC_ADR_T2_HI = 8'hcd;

	// ****************************************
	// timer two control fields and reset values
	// ****************************************
	localparam int TTC_T2_OVF = 7;
	localparam int TTC_T2_EXT = 6;
	localparam int TTC_T2_RCLK = 5;
	localparam int TTC_T2_SERIAL_TRANSMIT_CLOCK_SELECT = 4;
	localparam int TTC_T2_EXEN = 3;
	localparam int TTC_T2_RUN = 2;
	localparam int TTC_T2_FSEL = 1;
	localparam int TTC_T2_CAPSEL = 0;
	localparam logic [7:0] TTC_T2_CTL_RST = 8'h00;
	localparam logic [7:0] TTC_CNT_RST = 8'h00;
	localparam logic [7:0] TTC_RDATA_RST = 8'h00;
	localparam logic [7:0] TTC_UNMAPPED = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	// core clocks per machine cycle
	localparam int TTC_MC_DIV = 12;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		TTC_M13 = 2'h0,
		TTC_M16 = 2'h1,
		TTC_M8R = 2'h2,
		TTC_MSPLIT = 2'h3
	} ttc_tmode_t;

	typedef struct packed {
		logic gate;
		logic counter_sel;
		ttc_tmode_t mode;
	} ttc_tmode_cfg_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ttc_sfr_req_t;

	typedef struct packed {
		logic timer_zero_overflow_flag;
		logic timer_one_overflow_flag;
		logic timer_one_overflow_tick;
		logic serial_receive_clock_tick;
		logic serial_transmit_clock_tick;
	} ttc_evt_t;

endpackage : ttc_pkg

// file: hdl/ttc_prediv.sv
// machine cycle divider: one-cycle enable every DIV core clocks.
// assumes a single free-running ref_clk.
`timescale 1ns/1ps
module ttc_prediv #(
	parameter int DIV = 12
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	output logic tick
);
	import ttc_pkg::*;

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic wrap;

	generate
		if (DIV < 1) begin : g_chk
			$error("ttc_prediv needs DIV of at least one");
		end
	endgenerate

	assign wrap = (cnt_r == LAST);
	assign cnt_nxt = wrap ? '0 : cnt_r + CW'(1);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick <= wrap;
		end
	end

endmodule : ttc_prediv

// file: hdl/ttc_top.sv
// three timer/counters behind the special function register port.
// assumes timer zero and one mode and run bits come from the core's own registers as levels.
`timescale 1ns/1ps
module ttc_top #(
	parameter int MC_DIV = ttc_pkg::TTC_MC_DIV
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire ttc_pkg::ttc_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire ttc_pkg::ttc_tmode_cfg_t timer_zero_mode,
	input wire ttc_pkg::ttc_tmode_cfg_t timer_one_mode,
	input wire logic timer_zero_run_bit,
	input wire logic timer_one_run_bit,
	input wire logic timer_zero_vector_ack,
	input wire logic timer_one_vector_ack,
	input wire logic first_external_interrupt_pin,
	input wire logic second_external_interrupt_pin,
	input wire logic timer_zero_count_pin,
	input wire logic timer_one_count_pin,
	input wire logic timer_two_count_pin,
	input wire logic timer_two_trigger_input,
	output ttc_pkg::ttc_evt_t evt
);
	import ttc_pkg::*;

	// ****************************************
	// step function for timers zero and one
	// ****************************************
	// returns {overflow, high byte, low byte}
	function automatic logic [16:0] ttc_step(input ttc_tmode_t m, input logic [7:0] hi, input logic [7:0] lo);
		logic [12:0] c13;
		logic [15:0] c16;
		logic [16:0] r;
		c13 = {hi, lo[4:0]} + 13'h1;
		c16 = {hi, lo} + 16'h1;
		case (m)
			TTC_M13: r = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
			TTC_M16: r = {&{hi, lo}, c16};
			TTC_M8R: r = {&lo, hi, (&lo) ? hi : lo + 8'h1};
			default: r = {&lo, hi, lo + 8'h1};
		endcase
		return r;
	endfunction : ttc_step

	// ****************************************
	// state
	// ****************************************
	logic [7:0] t0_lo_r, t0_hi_r, t1_lo_r, t1_hi_r;
	logic [7:0] t2_lo_r, t2_hi_r, snap_lo_r, snap_hi_r;
	logic [7:0] t2_ctl_r;
	logic [7:0] t0_lo_nxt, t0_hi_nxt, t1_lo_nxt, t1_hi_nxt;
	logic [7:0] t2_lo_nxt, t2_hi_nxt, snap_lo_nxt, snap_hi_nxt;
	logic [7:0] t2_ctl_nxt;
	logic tf0_nxt, tf1_nxt;
	logic [7:0] rd_val;

	// ****************************************
	// shared enables
	// ****************************************
	logic mc_en;
	logic [3:0] pin_fall;

	ttc_prediv #(
		.DIV(MC_DIV)
	) u_prediv (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tick(mc_en)
	);

	ttc_fall #(
		.W(4)
	) u_fall (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level({timer_two_trigger_input, timer_two_count_pin, timer_one_count_pin, timer_zero_count_pin}),
		.fall(pin_fall)
	);

	// ****************************************
	// register decode
	// ****************************************
	wire wr_t0_lo = sfr_req.wr && (sfr_req.addr == TTC_ADR_T0_LO);
	wire wr_t0_hi = sfr_req.wr && (sfr_req.addr == TTC_ADR_T0_HI);
	wire wr_t1_lo = sfr_req.wr && (sfr_req.addr == TTC_ADR_T1_LO);
	wire wr_t1_hi = sfr_req.wr && (sfr_req.addr == TTC_ADR_T1_HI);
	wire wr_t2_ctl = sfr_req.wr && (sfr_req.addr == TTC_ADR_T2_CTL);
	wire wr_snap_lo = sfr_req.wr && (sfr_req.addr == TTC_ADR_T2_SNAP_LO);
	wire wr_snap_hi = sfr_req.wr && (sfr_req.addr == TTC_ADR_T2_SNAP_HI);
	wire wr_t2_lo = sfr_req.wr && (sfr_req.addr == TTC_ADR_T2_LO);
	wire wr_t2_hi = sfr_req.wr && (sfr_req.addr == TTC_ADR_T2_HI);

	assign rd_val = (sfr_req.addr == TTC_ADR_T0_LO) ? t0_lo_r :
		(sfr_req.addr == TTC_ADR_T0_HI) ? t0_hi_r :
		(sfr_req.addr == TTC_ADR_T1_LO) ? t1_lo_r :
		(sfr_req.addr == TTC_ADR_T1_HI) ? t1_hi_r :
		(sfr_req.addr == TTC_ADR_T2_CTL) ? t2_ctl_r :
		(sfr_req.addr == TTC_ADR_T2_SNAP_LO) ? snap_lo_r :
		(sfr_req.addr == TTC_ADR_T2_SNAP_HI) ? snap_hi_r :
		(sfr_req.addr == TTC_ADR_T2_LO) ? t2_lo_r :
		(sfr_req.addr == TTC_ADR_T2_HI) ? t2_hi_r : TTC_UNMAPPED;

	// ****************************************
	// timers zero and one
	// ****************************************
	wire t0_split = (timer_zero_mode.mode == TTC_MSPLIT);
	wire t1_hold = (timer_one_mode.mode == TTC_MSPLIT);
	wire t0_src = timer_zero_mode.counter_sel ? pin_fall[0] : mc_en;
	wire t1_src = timer_one_mode.counter_sel ? pin_fall[1] : mc_en;
	wire t0_qual = timer_zero_run_bit && (!timer_zero_mode.gate || first_external_interrupt_pin);
	wire t1_qual = timer_one_run_bit && (!timer_one_mode.gate || second_external_interrupt_pin);
	// with timer zero split, timer one runs whenever it is out of mode 3
	wire t1_run = !t1_hold && (t0_split ? 1'b1 : t1_qual);
	wire t0_inc = t0_src && t0_qual;
	wire t1_inc = t1_src && t1_run;
	wire th0_inc = t0_split && mc_en && timer_one_run_bit;

	wire [16:0] t0_step = ttc_step(ttc_tmode_t'(timer_zero_mode.mode), t0_hi_r, t0_lo_r);
	wire [16:0] t1_step = ttc_step(ttc_tmode_t'(timer_one_mode.mode), t1_hi_r, t1_lo_r);
	wire t0_ovf = t0_inc && t0_step[16];
	wire th0_ovf = th0_inc && (&t0_hi_r);
	wire t1_ovf = t1_inc && t1_step[16];

	// a software write to a byte wins over the count in that cycle
	assign t0_lo_nxt = wr_t0_lo ? sfr_req.wdata : t0_inc ? t0_step[7:0] : t0_lo_r;
	assign t0_hi_nxt = wr_t0_hi ? sfr_req.wdata :
		t0_split ? (th0_inc ? t0_hi_r + 8'h1 : t0_hi_r) :
		t0_inc ? t0_step[15:8] : t0_hi_r;
	assign t1_lo_nxt = wr_t1_lo ? sfr_req.wdata : t1_inc ? t1_step[7:0] : t1_lo_r;
	assign t1_hi_nxt = wr_t1_hi ? sfr_req.wdata : t1_inc ? t1_step[15:8] : t1_hi_r;

	// set wins over the acknowledge
	assign tf0_nxt = t0_ovf || (evt.timer_zero_overflow_flag && !timer_zero_vector_ack);
	assign tf1_nxt = (t0_split ? th0_ovf : t1_ovf) || (evt.timer_one_overflow_flag && !timer_one_vector_ack);

	// ****************************************
	// timer two
	// ****************************************
	wire t2_run = t2_ctl_r[TTC_T2_RUN];
	wire baud = t2_ctl_r[TTC_T2_RCLK] || t2_ctl_r[TTC_T2_SERIAL_TRANSMIT_CLOCK_SELECT];
	wire cap_sel = t2_ctl_r[TTC_T2_CAPSEL];
	wire t2_inc = t2_run && (t2_ctl_r[TTC_T2_FSEL] ? pin_fall[2] : 1'b1);
	wire t2_ovf = t2_inc && (&{t2_hi_r, t2_lo_r});
	wire t2_trig = t2_run && t2_ctl_r[TTC_T2_EXEN] && !baud && pin_fall[3];
	wire t2_reload = (t2_ovf && (baud || !cap_sel)) || (t2_trig && !cap_sel);
	wire t2_capture = t2_trig && cap_sel;
	wire [15:0] t2_sum = {t2_hi_r, t2_lo_r} + 16'h1;
	wire [15:0] t2_cnt = t2_reload ? {snap_hi_r, snap_lo_r} : t2_inc ? t2_sum : {t2_hi_r, t2_lo_r};

	assign t2_lo_nxt = wr_t2_lo ? sfr_req.wdata : t2_cnt[7:0];
	assign t2_hi_nxt = wr_t2_hi ? sfr_req.wdata : t2_cnt[15:8];
	// a capture wins over a software write to the snapshot pair
	assign snap_lo_nxt = t2_capture ? t2_lo_r : wr_snap_lo ? sfr_req.wdata : snap_lo_r;
	assign snap_hi_nxt = t2_capture ? t2_hi_r : wr_snap_hi ? sfr_req.wdata : snap_hi_r;

	wire [7:0] t2_ctl_base = wr_t2_ctl ? sfr_req.wdata : t2_ctl_r;
	wire [7:0] t2_ctl_set = {t2_ovf && !baud, t2_trig, 6'h00};
	assign t2_ctl_nxt = t2_ctl_base | t2_ctl_set;

	// ****************************************
	// serial clock ticks
	// ****************************************
	wire rx_tick_nxt = t2_ctl_r[TTC_T2_RCLK] ? t2_ovf : t1_ovf;
	wire tx_tick_nxt = t2_ctl_r[TTC_T2_SERIAL_TRANSMIT_CLOCK_SELECT] ? t2_ovf : t1_ovf;

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			t0_lo_r <= TTC_CNT_RST;
			t0_hi_r <= TTC_CNT_RST;
			t1_lo_r <= TTC_CNT_RST;
			t1_hi_r <= TTC_CNT_RST;
		end else begin
			t0_lo_r <= t0_lo_nxt;
			t0_hi_r <= t0_hi_nxt;
			t1_lo_r <= t1_lo_nxt;
			t1_hi_r <= t1_hi_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			t2_lo_r <= TTC_CNT_RST;
			t2_hi_r <= TTC_CNT_RST;
			snap_lo_r <= TTC_CNT_RST;
			snap_hi_r <= TTC_CNT_RST;
			t2_ctl_r <= TTC_T2_CTL_RST;
		end else begin
			t2_lo_r <= t2_lo_nxt;
			t2_hi_r <= t2_hi_nxt;
			snap_lo_r <= snap_lo_nxt;
			snap_hi_r <= snap_hi_nxt;
			t2_ctl_r <= t2_ctl_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			evt <= '0;
			sfr_rdata <= TTC_RDATA_RST;
		end else begin
			evt.timer_zero_overflow_flag <= tf0_nxt;
			evt.timer_one_overflow_flag <= tf1_nxt;
			evt.timer_one_overflow_tick <= t1_ovf;
			evt.serial_receive_clock_tick <= rx_tick_nxt;
			evt.serial_transmit_clock_tick <= tx_tick_nxt;
			sfr_rdata <= sfr_req.rd ? rd_val : sfr_rdata;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	property p_m1_wrap;
		(timer_zero_mode.mode == TTC_M16) && t0_inc && ({t0_hi_r, t0_lo_r} == 16'hffff) && !wr_t0_lo && !wr_t0_hi
		|=> evt.timer_zero_overflow_flag && (t0_lo_r == 8'h00) && (t0_hi_r == 8'h00);
	endproperty
	a_m1_wrap: assert property (p_m1_wrap) else $error("mode 1 wrap did not set flag and clear count");

	property p_m0_prescale;
		(timer_zero_mode.mode == TTC_M13) && t0_inc && (t0_lo_r[4:0] == 5'h1f) && !wr_t0_lo && !wr_t0_hi
		|=> (t0_lo_r[4:0] == 5'h00) && (t0_hi_r == $past(t0_hi_r) + 8'h1) && (t0_lo_r[7:5] == $past(t0_lo_r[7:5]));
	endproperty
	a_m0_prescale: assert property (p_m0_prescale) else $error("mode 0 carry out of five low bits wrong");

	property p_m2_reload;
		(timer_one_mode.mode == TTC_M8R) && t1_inc && (t1_lo_r == 8'hff) && !wr_t1_lo && !wr_t1_hi
		|=> (t1_lo_r == $past(t1_hi_r)) && (t1_hi_r == $past(t1_hi_r));
	endproperty
	a_m2_reload: assert property (p_m2_reload) else $error("mode 2 reload from high byte failed");

	property p_gate_hold;
		(!timer_zero_run_bit || (timer_zero_mode.gate && !first_external_interrupt_pin)) && !t0_split
		&& !wr_t0_lo && !wr_t0_hi |=> $stable(t0_lo_r) && $stable(t0_hi_r);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("timer zero counted while not qualified");

	property p_run_keeps;
		$rose(timer_one_run_bit) && !t1_inc && !wr_t1_lo && !wr_t1_hi |=> $stable(t1_lo_r) && $stable(t1_hi_r);
	endproperty
	a_run_keeps: assert property (p_run_keeps) else $error("setting run bit disturbed count");

	property p_t1_hold;
		t1_hold && !wr_t1_lo && !wr_t1_hi |=> $stable(t1_lo_r) && $stable(t1_hi_r);
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("timer one moved in mode 3");

	property p_split_hi;
		t0_split && mc_en && timer_one_run_bit && (t0_hi_r == 8'hff) && !wr_t0_hi
		|=> evt.timer_one_overflow_flag && (t0_hi_r == 8'h00);
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split high byte did not set timer one flag");

	property p_ack_clear;
		evt.timer_zero_overflow_flag && timer_zero_vector_ack && !t0_ovf |=> !evt.timer_zero_overflow_flag;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("vector acknowledge did not clear flag");

	property p_baud_no_flag;
		baud && !wr_t2_ctl |=> !$rose(t2_ctl_r[TTC_T2_OVF]);
	endproperty
	a_baud_no_flag: assert property (p_baud_no_flag) else $error("overflow flag set in baud mode");

	property p_trig_flag;
		t2_trig |=> t2_ctl_r[TTC_T2_EXT];
	endproperty
	a_trig_flag: assert property (p_trig_flag) else $error("trigger edge did not set external flag");

	property p_capture;
		t2_trig && cap_sel |=> (snap_lo_r == $past(t2_lo_r)) && (snap_hi_r == $past(t2_hi_r));
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not copy count");

	property p_reload;
		t2_ovf && (baud || !cap_sel) && !wr_t2_lo && !wr_t2_hi
		|=> ({t2_hi_r, t2_lo_r} == $past({snap_hi_r, snap_lo_r}));
	endproperty
	a_reload: assert property (p_reload) else $error("rollover did not reload from snapshot");

	property p_t2_off;
		!t2_run && !wr_t2_lo && !wr_t2_hi && !wr_t2_ctl ##0 !wr_snap_lo && !wr_snap_hi
		|=> $stable({t2_hi_r, t2_lo_r}) && $stable({snap_hi_r, snap_lo_r}) && !$rose(t2_ctl_r[TTC_T2_EXT]);
	endproperty
	a_t2_off: assert property (p_t2_off) else $error("timer two acted while stopped");

	property p_rx_tick;
		t2_ctl_r[TTC_T2_RCLK] && t2_ovf |=> evt.serial_receive_clock_tick;
	endproperty
	a_rx_tick: assert property (p_rx_tick) else $error("receive tick missed timer two overflow");

	property p_t1_gate_hold;
		(!timer_one_run_bit || (timer_one_mode.gate && !second_external_interrupt_pin)) && !t0_split
		&& !wr_t1_lo && !wr_t1_hi |=> $stable(t1_lo_r) && $stable(t1_hi_r);
	endproperty
	a_t1_gate_hold: assert property (p_t1_gate_hold) else $error("timer one counted while not qualified");

	property p_split_t1_runs;
		t0_split && (timer_one_mode.mode == TTC_M8R) && !timer_one_mode.counter_sel && mc_en
		&& !wr_t1_lo && !wr_t1_hi
		|=> t1_lo_r == (($past(t1_lo_r) == 8'hff) ? $past(t1_hi_r) : $past(t1_lo_r) + 8'h1);
	endproperty
	a_split_t1_runs: assert property (p_split_t1_runs) else $error("timer one idle out of mode 3");

	property p_split_t1_tick;
		t0_split && t1_ovf && !th0_ovf && !evt.timer_one_overflow_flag
		|=> evt.timer_one_overflow_tick && !evt.timer_one_overflow_flag;
	endproperty
	a_split_t1_tick: assert property (p_split_t1_tick) else $error("timer one overflow wrong in split");

	property p_trig_ignored;
		pin_fall[3] && (!t2_ctl_r[TTC_T2_EXEN] || baud) && !wr_t2_ctl && !wr_snap_lo && !wr_snap_hi
		|=> !$rose(t2_ctl_r[TTC_T2_EXT]) && $stable({snap_hi_r, snap_lo_r});
	endproperty
	a_trig_ignored: assert property (p_trig_ignored) else $error("trigger acted while disabled");

	property p_pin_idle;
		t2_run && t2_ctl_r[TTC_T2_FSEL] && !pin_fall[2] && !t2_trig && !wr_t2_lo && !wr_t2_hi
		|=> $stable({t2_hi_r, t2_lo_r});
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("timer two counted without pin edge");

	property p_pin_count;
		t2_run && t2_ctl_r[TTC_T2_FSEL] && pin_fall[2] && !t2_trig && !(&{t2_hi_r, t2_lo_r})
		&& !wr_t2_lo && !wr_t2_hi
		|=> ({t2_hi_r, t2_lo_r} == $past({t2_hi_r, t2_lo_r}) + 16'h1);
	endproperty
	a_pin_count: assert property (p_pin_count) else $error("timer two missed a pin edge");

	property p_trig_reload;
		t2_trig && !cap_sel && !wr_t2_lo && !wr_t2_hi |=> ({t2_hi_r, t2_lo_r} == $past({snap_hi_r, snap_lo_r}));
	endproperty
	a_trig_reload: assert property (p_trig_reload) else $error("trigger edge did not reload");

	property p_split_lo;
		t0_split && (!timer_zero_run_bit || (timer_zero_mode.gate && !first_external_interrupt_pin)) && !wr_t0_lo
		|=> $stable(t0_lo_r);
	endproperty
	a_split_lo: assert property (p_split_lo) else $error("split low byte ignored its controls");

	c_t0_wrap: cover property (t0_ovf ##1 evt.timer_zero_overflow_flag);
	c_split: cover property (t0_split && th0_ovf);
	c_capture: cover property (t2_capture);
	c_count_pin: cover property (t2_inc && t2_ctl_r[TTC_T2_FSEL]);
	c_baud: cover property (baud && t2_ovf ##1 evt.serial_transmit_clock_tick);

endmodule : ttc_top

// file: test/tb_ttc_top.sv
// self-checking bench for the three-timer counter unit.
// assumes the pin model drives all external pins; MC_DIV shortened to 2.
`timescale 1ns/1ps
module tb_ttc_top;
	import ttc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	ttc_sfr_req_t req = '0;
	logic [7:0] rdata;
	ttc_tmode_cfg_t m0 = '0;
	ttc_tmode_cfg_t m1 = '0;
	logic run0 = 1'b0;
	logic run1 = 1'b0;
	logic ack0 = 1'b0;
	logic ack1 = 1'b0;
	logic g0;
	logic g1;
	logic [3:0] fp;
	ttc_evt_t evt;
	int err_count = 0;
	int num_checks = 0;

	always #12.5 ref_clk = ~ref_clk;

	ttc_pin_model pins (.ref_clk(ref_clk), .gate0_pin(g0), .gate1_pin(g1), .fall_pins(fp));

	ttc_top #(.MC_DIV(2)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata),
		.timer_zero_mode(m0), .timer_one_mode(m1), .timer_zero_run_bit(run0), .timer_one_run_bit(run1),
		.timer_zero_vector_ack(ack0), .timer_one_vector_ack(ack1),
		.first_external_interrupt_pin(g0), .second_external_interrupt_pin(g1),
		.timer_zero_count_pin(fp[0]), .timer_one_count_pin(fp[1]), .timer_two_count_pin(fp[2]),
		.timer_two_trigger_input(fp[3]), .evt(evt)
	);

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// evt bits: 4 t0 flag, 3 t1 flag, 2 t1 tick, 1 rx tick, 0 tx tick
	task automatic bchk(input int b, input logic e);
		chk({7'h00, evt[b]}, {7'h00, e});
	endtask : bchk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge ref_clk);
		req <= '0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req <= '0;
		#1;
		chk(rdata, exp);
	endtask : rchk

	task automatic wait_evt(input int b, input int lim);
		int n;
		n = 0;
		while (evt[b] !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask : wait_evt

	task automatic ack(input int t);
		@(posedge ref_clk);
		if (t == 0) ack0 <= 1'b1; else ack1 <= 1'b1;
		@(posedge ref_clk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
		#1;
		bchk(4 - t, 1'b0);
	endtask : ack

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		logic [7:0] adr [8] = '{TTC_ADR_T0_LO, TTC_ADR_T1_LO, TTC_ADR_T0_HI, TTC_ADR_T1_HI,
			TTC_ADR_T2_SNAP_LO, TTC_ADR_T2_SNAP_HI, TTC_ADR_T2_LO, TTC_ADR_T2_HI};
		rchk(TTC_ADR_T2_CTL, 8'h00);
		rchk(TTC_ADR_T0_LO, TTC_CNT_RST);
		wr(8'h80, 8'h5a);
		rchk(8'h80, TTC_UNMAPPED);
		for (int i = 0; i < 8; i++) begin
			wr(adr[i], 8'h31 + 8'(i * 17));
			rchk(adr[i], 8'h31 + 8'(i * 17));
		end
		wr(TTC_ADR_T2_CTL, 8'h02);
		rchk(TTC_ADR_T2_CTL, 8'h02);
		$display("registers test done");
	endtask : t_regs

	task automatic t_mode1;
		m0 <= '{gate: 1'b0, counter_sel: 1'b0, mode: TTC_M16};
		wr(TTC_ADR_T0_HI, 8'hff);
		wr(TTC_ADR_T0_LO, 8'hde);
		run0 <= 1'b1;
		repeat (20) @(posedge ref_clk);
		#1;
		bchk(4, 1'b0);
		wait_evt(4, 200);
		bchk(4, 1'b1);
		run0 <= 1'b0;
		rchk(TTC_ADR_T0_HI, 8'h00);
		ack(0);
		$display("mode 1 test done");
	endtask : t_mode1

	task automatic t_gate;
		m0 <= '{gate: 1'b1, counter_sel: 1'b0, mode: TTC_M13};
		pins.set_gate(1'b0, 1'b1);
		wr(TTC_ADR_T0_HI, 8'hff);
		wr(TTC_ADR_T0_LO, 8'hfe);
		run0 <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rchk(TTC_ADR_T0_LO, 8'hfe);
		pins.set_gate(1'b1, 1'b1);
		wait_evt(4, 20);
		bchk(4, 1'b1);
		run0 <= 1'b0;
		rchk(TTC_ADR_T0_HI, 8'h00);
		ack(0);
		$display("gate test done");
	endtask : t_gate

	task automatic t_reload8;
		m1 <= '{gate: 1'b1, counter_sel: 1'b0, mode: TTC_M8R};
		pins.set_gate(1'b1, 1'b0);
		wr(TTC_ADR_T1_HI, 8'ha5);
		wr(TTC_ADR_T1_LO, 8'hfd);
		run1 <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rchk(TTC_ADR_T1_LO, 8'hfd);
		pins.set_gate(1'b1, 1'b1);
		wait_evt(3, 40);
		bchk(3, 1'b1);
		run1 <= 1'b0;
		rchk(TTC_ADR_T1_HI, 8'ha5);
		rchk(TTC_ADR_T1_LO, 8'ha5);
		chk({7'h00, rdata >= 8'ha5 && rdata <= 8'haa}, 8'h01);
		ack(1);
		$display("mode 2 test done");
	endtask : t_reload8

	task automatic t_split;
		m0 <= '{gate: 1'b0, counter_sel: 1'b0, mode: TTC_MSPLIT};
		m1 <= '{gate: 1'b0, counter_sel: 1'b0, mode: TTC_MSPLIT};
		wr(TTC_ADR_T0_HI, 8'hfe);
		wr(TTC_ADR_T0_LO, 8'h40);
		wr(TTC_ADR_T1_LO, 8'h77);
		run1 <= 1'b1;
		wait_evt(3, 40);
		bchk(3, 1'b1);
		bchk(4, 1'b0);
		run1 <= 1'b0;
		rchk(TTC_ADR_T0_LO, 8'h40);
		rchk(TTC_ADR_T1_LO, 8'h77);
		ack(1);
		wr(TTC_ADR_T1_LO, 8'hfe);
		m1 <= '{gate: 1'b0, counter_sel: 1'b0, mode: TTC_M8R};
		wait_evt(2, 40);
		bchk(2, 1'b1);
		bchk(3, 1'b0);
		m0 <= '0;
		m1 <= '0;
		$display("split test done");
	endtask : t_split

	task automatic t_count_pins;
		m0 <= '{gate: 1'b0, counter_sel: 1'b1, mode: TTC_M16};
		m1 <= '{gate: 1'b0, counter_sel: 1'b1, mode: TTC_M16};
		wr(TTC_ADR_T0_LO, 8'h00);
		wr(TTC_ADR_T0_HI, 8'h00);
		wr(TTC_ADR_T1_LO, 8'h00);
		wr(TTC_ADR_T1_HI, 8'h00);
		run0 <= 1'b1;
		run1 <= 1'b1;
		pins.pulse(0);
		pins.pulse(0);
		pins.pulse(1);
		run0 <= 1'b0;
		run1 <= 1'b0;
		rchk(TTC_ADR_T0_LO, 8'h02);
		rchk(TTC_ADR_T0_HI, 8'h00);
		rchk(TTC_ADR_T1_LO, 8'h01);
		m0 <= '0;
		m1 <= '0;
		$display("count pin test done");
	endtask : t_count_pins

	task automatic t_capture;
		wr(TTC_ADR_T2_LO, 8'h34);
		wr(TTC_ADR_T2_HI, 8'h12);
		wr(TTC_ADR_T2_CTL, 8'h0b);
		pins.pulse(3);
		rchk(TTC_ADR_T2_CTL, 8'h0b);
		wr(TTC_ADR_T2_CTL, 8'h07);
		pins.pulse(3);
		rchk(TTC_ADR_T2_CTL, 8'h07);
		wr(TTC_ADR_T2_CTL, 8'h0f);
		pins.pulse(3);
		rchk(TTC_ADR_T2_CTL, 8'h4f);
		rchk(TTC_ADR_T2_SNAP_LO, 8'h34);
		rchk(TTC_ADR_T2_SNAP_HI, 8'h12);
		pins.pulse(2);
		rchk(TTC_ADR_T2_LO, 8'h35);
		$display("capture test done");
	endtask : t_capture

	task automatic t_autoreload;
		wr(TTC_ADR_T2_CTL, 8'h00);
		wr(TTC_ADR_T2_SNAP_LO, 8'hcd);
		wr(TTC_ADR_T2_SNAP_HI, 8'hab);
		wr(TTC_ADR_T2_CTL, 8'h0e);
		pins.pulse(3);
		rchk(TTC_ADR_T2_CTL, 8'h4e);
		rchk(TTC_ADR_T2_LO, 8'hcd);
		wr(TTC_ADR_T2_CTL, 8'h00);
		wr(TTC_ADR_T2_HI, 8'hff);
		wr(TTC_ADR_T2_LO, 8'hfc);
		wr(TTC_ADR_T2_CTL, 8'h04);
		repeat (6) @(posedge ref_clk);
		rchk(TTC_ADR_T2_CTL, 8'h84);
		rchk(TTC_ADR_T2_HI, 8'hab);
		wr(TTC_ADR_T2_CTL, 8'h00);
		wr(TTC_ADR_T2_HI, 8'hff);
		wr(TTC_ADR_T2_LO, 8'hf0);
		wr(TTC_ADR_T2_CTL, 8'h35);
		wait_evt(1, 40);
		bchk(1, 1'b1);
		bchk(0, 1'b1);
		rchk(TTC_ADR_T2_HI, 8'hab);
		rchk(TTC_ADR_T2_CTL, 8'h35);
		wr(TTC_ADR_T2_CTL, 8'h00);
		$display("auto-reload test done");
	endtask : t_autoreload

	// ****************************************
	// run control
	// ****************************************
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_regs();
		t_mode1();
		t_gate();
		t_reload8();
		t_split();
		t_count_pins();
		t_capture();
		t_autoreload();
		complete_run();
	end

	initial begin
		#(25 * 20000);
		err_count++;
		complete_run();
	end
endmodule : tb_ttc_top

// file: test/ttc_pin_model.sv
// pin-side model of the unit's surroundings: gate levels, count pins and trigger.
// assumes the bench calls its tasks from one process at a time, on ref_clk.
`timescale 1ns/1ps
module ttc_pin_model (
	input wire logic ref_clk,
	output logic gate0_pin,
	output logic gate1_pin,
	output logic [3:0] fall_pins
);
	// ****************************************
	// idle levels
	// ****************************************
	initial begin
		gate0_pin = 1'b1;
		gate1_pin = 1'b1;
		fall_pins = 4'hf;
	end

	// ****************************************
	// drivers
	// ****************************************
	task automatic set_gate(input logic g0, input logic g1);
		@(posedge ref_clk);
		gate0_pin <= g0;
		gate1_pin <= g1;
	endtask : set_gate

	// one falling edge, held low long enough to be seen, then back to idle high
	task automatic pulse(input int idx);
		@(posedge ref_clk);
		fall_pins[idx] <= 1'b0;
		repeat (3) @(posedge ref_clk);
		fall_pins[idx] <= 1'b1;
		@(posedge ref_clk);
	endtask : pulse
endmodule : ttc_pin_model
